// ### serial_sram_command_interface.sv
// Command decoder, serial shifters and write buffer of the serial SRAM.
//
// Contract
// - Read is opcode then 24-bit address; top 7 address bits are ignored.
// - One-bit mode drives read data right after the last address bit.
// - Reads wait four dummy clocks in two-bit, two in four-bit mode.
// - Read pointer advances per byte and wraps from 1FFFFh to 00000h.
// - Chip select high ends any read.
// - Write is opcode, 24-bit address with top 7 ignored, then data bytes.
// - Page mode wraps the pointer inside the current 32-byte page.
// - Burst mode advances over the whole array, wrapping to zero.
// - Chip select high ends a write; no more data is taken.
// - Mode register read outputs the register repeatedly until deselect.
// - Mode register write takes the next byte; deselect commits it.
// - Mode bit 0 set disables pause; clear enables it, the default.
// - Mode bits 7:6 select word, page or burst writes; burst default.
// - After power-up the device stays idle until chip select goes low.
// - The battery variant refuses four-bit mode.
// - Battery variant keeps width and mode register through supply loss.
// - Opcode set as listed; all fields travel most significant bit first.
// - Inputs captured on rising clock, outputs updated on falling clock.
// - Wide modes persist until the return opcode or, in the standard variant, power loss.
// - Pause freezes the transfer and floats outputs in one or two-bit mode of the standard variant; the battery variant never pauses.
`timescale 1ns/1ps
module serial_sram_command_interface #(
  parameter bit BATTERY_BACKED = 1'b0,
  parameter int ADDR_W = sram_pkg::ADDR_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic powerGood,
  input wire logic csN,
  input wire logic sck,
  input wire logic [3:0] ioIn,
  output logic [3:0] ioOut,
  output logic [3:0] ioOe
);

  // ==========================================================================
  // State
  typedef struct packed {
    sram_pkg::state_e state;
    sram_pkg::width_e width;
    logic [7:0] mode;
    logic [7:0] modePend;
    logic modeLoad;
    logic isWrite;
    logic sckPrev;
    logic csPrev;
    logic held;
    logic [31:0] sr;
    logic [5:0] bitCnt;
    logic [2:0] dummyCnt;
    logic [ADDR_W-1:0] ptr;
    logic [7:0] outShift;
    logic [2:0] outCnt;
    logic [3:0] ioOut;
    logic [3:0] drvOe;
    logic [3:0] oeLive;
    logic rdReq;
    logic wrPend;
    logic [ADDR_W+7:0] wrWord;
    logic [1:0][ADDR_W+7:0] buffer;
    logic [1:0] bufCnt;
  } st_s;

  localparam st_s RESET_ST = '{
    state: sram_pkg::ST_IDLE,
    width: sram_pkg::BUS_ONE,
    mode: sram_pkg::MODE_RESET,
    default: '0
  };

  st_s q;
  st_s d;
  logic rise;
  logic fall;
  logic holdAllowed;
  logic addrDone;
  logic byteDone;
  logic bufReady;
  logic [31:0] srNext;
  logic [5:0] bitNext;
  logic memWe;
  logic memEn;
  logic [ADDR_W-1:0] memAddr;
  logic [7:0] memRdata;
  logic [7:0] word;

  function automatic logic [ADDR_W-1:0] nextWrPtr(input logic [ADDR_W-1:0] p,
                                                  input logic [1:0] wm);
    if (wm == sram_pkg::WMODE_PAGE) begin
      nextWrPtr = {p[ADDR_W-1:sram_pkg::PAGE_BITS],
                   p[sram_pkg::PAGE_BITS-1:0] + 1'b1};
    end else begin
      nextWrPtr = p + 1'b1;
    end
  endfunction

  // ==========================================================================
  // Array port: pending reads win, the write buffer drains otherwise.
  assign memWe = (q.bufCnt != 2'h0) && !q.rdReq;
  assign memEn = q.rdReq || memWe;
  assign memAddr = q.rdReq ? q.ptr : q.buffer[0][ADDR_W+7:8];

  sram_array #(.ADDR_W(ADDR_W), .DATA_W(sram_pkg::DATA_W)) sram_array_inst (
    .clk(clk),
    .en(memEn),
    .we(memWe),
    .addr(memAddr),
    .wdata(q.buffer[0][7:0]),
    .rdata(memRdata)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    d = q;
    d.rdReq = 1'b0;
    d.sckPrev = sck;
    d.csPrev = csN;
    word = q.outShift;
    srNext = sram_pkg::shiftIn(q.sr, ioIn, q.width);
    bitNext = q.bitCnt + sram_pkg::bitsPer(q.width);
    rise = sck && !q.sckPrev && !q.held;
    fall = !sck && q.sckPrev && !q.held;
    addrDone = rise && (q.state == sram_pkg::ST_ADDR) && (bitNext == sram_pkg::ADDR_BITS);
    byteDone = rise && (q.state == sram_pkg::ST_WR_DATA) && (bitNext == sram_pkg::BYTE_BITS);
    holdAllowed = !BATTERY_BACKED && (q.width != sram_pkg::BUS_FOUR) &&
                  !q.mode[sram_pkg::HOLD_DIS_BIT] && (q.state != sram_pkg::ST_IDLE);

    // Pause takes effect and ends only while the serial clock is low.
    if (holdAllowed) begin
      if (!q.held && !ioIn[3] && !sck) begin
        d.held = 1'b1;
      end else if (q.held && ioIn[3] && !sck) begin
        d.held = 1'b0;
      end
    end else begin
      d.held = 1'b0;
    end

    // Two-entry write buffer: drain to the array, then take the pending byte.
    if (memWe) begin
      d.buffer[0] = q.buffer[1];
      d.bufCnt = q.bufCnt - 2'h1;
    end
    bufReady = (d.bufCnt != 2'h2);
    if (q.wrPend && bufReady) begin
      d.buffer[d.bufCnt[0]] = q.wrWord;
      d.bufCnt = d.bufCnt + 2'h1;
      d.wrPend = 1'b0;
    end

    if (csN) begin
      d.state = sram_pkg::ST_IDLE;
      d.drvOe = 4'h0;
      d.held = 1'b0;
      if (q.modeLoad) begin
        d.mode = q.modePend;
        d.modeLoad = 1'b0;
      end
    end else if (q.state == sram_pkg::ST_IDLE) begin
      if (q.csPrev) begin
        d.state = sram_pkg::ST_CMD;
        d.bitCnt = 6'h00;
      end
    end else if (rise) begin
      d.sr = srNext;
      d.bitCnt = bitNext;
      case (q.state)
        sram_pkg::ST_CMD: begin
          if (bitNext == sram_pkg::CMD_BITS) begin
            d.bitCnt = 6'h00;
            d.state = sram_pkg::ST_IGNORE;
            case (srNext[7:0])
              sram_pkg::OP_READ: begin
                d.state = sram_pkg::ST_ADDR;
                d.isWrite = 1'b0;
              end
              sram_pkg::OP_WRITE: begin
                d.state = sram_pkg::ST_ADDR;
                d.isWrite = 1'b1;
              end
              sram_pkg::OP_READ_MODE_REG: begin
                d.state = sram_pkg::ST_MODE_RD;
                d.outCnt = 3'h0;
              end
              sram_pkg::OP_WRITE_MODE_REG: begin
                d.state = sram_pkg::ST_MODE_WR;
              end
              sram_pkg::OP_ENTER_FOUR_BIT: begin
                if (!BATTERY_BACKED) begin
                  d.width = sram_pkg::BUS_FOUR;
                end
              end
              sram_pkg::OP_ENTER_TWO_BIT: begin
                d.width = sram_pkg::BUS_TWO;
              end
              sram_pkg::OP_RETURN_SINGLE_BIT: begin
                d.width = sram_pkg::BUS_ONE;
              end
              default: begin
              end
            endcase
          end
        end
        sram_pkg::ST_ADDR: begin
          if (addrDone) begin
            d.ptr = srNext[ADDR_W-1:0];
            d.bitCnt = 6'h00;
            d.outCnt = 3'h0;
            d.dummyCnt = 3'h0;
            if (q.isWrite) begin
              d.state = sram_pkg::ST_WR_DATA;
            end else if (q.width == sram_pkg::BUS_ONE) begin
              d.state = sram_pkg::ST_RD_DATA;
              d.rdReq = 1'b1;
            end else begin
              d.state = sram_pkg::ST_DUMMY;
              d.rdReq = 1'b1;
            end
          end
        end
        sram_pkg::ST_DUMMY: begin
          d.dummyCnt = q.dummyCnt + 3'h1;
          if (d.dummyCnt == ((q.width == sram_pkg::BUS_TWO) ?
              sram_pkg::DUMMY_TWO_BIT : sram_pkg::DUMMY_FOUR_BIT)) begin
            d.state = sram_pkg::ST_RD_DATA;
          end
        end
        sram_pkg::ST_WR_DATA: begin
          if (byteDone) begin
            d.bitCnt = 6'h00;
            d.wrPend = 1'b1;
            d.wrWord = {q.ptr, srNext[7:0]};
            d.ptr = nextWrPtr(q.ptr, q.mode[sram_pkg::WMODE_HI:sram_pkg::WMODE_LO]);
            if (q.mode[sram_pkg::WMODE_HI:sram_pkg::WMODE_LO] == sram_pkg::WMODE_WORD) begin
              d.state = sram_pkg::ST_IGNORE;
            end
          end
        end
        sram_pkg::ST_MODE_WR: begin
          if (bitNext == sram_pkg::BYTE_BITS) begin
            d.modePend = srNext[7:0];
            d.modeLoad = 1'b1;
            d.state = sram_pkg::ST_IGNORE;
          end
        end
        default: begin
        end
      endcase
    end else if (fall && ((q.state == sram_pkg::ST_RD_DATA) ||
                          (q.state == sram_pkg::ST_MODE_RD))) begin
      if (q.outCnt == 3'h0) begin
        if (q.state == sram_pkg::ST_RD_DATA) begin
          word = memRdata;
          d.ptr = q.ptr + 1'b1;
          d.rdReq = 1'b1;
        end else begin
          word = q.mode;
        end
        d.outCnt = sram_pkg::lastBeat(q.width);
      end else begin
        d.outCnt = q.outCnt - 3'h1;
      end
      d.ioOut = sram_pkg::drive(word, q.width);
      d.drvOe = sram_pkg::oeMask(q.width);
      d.outShift = word << sram_pkg::bitsPer(q.width);
    end

    // Supply loss: standby; only the battery variant keeps its settings.
    if (!powerGood) begin
      d.state = sram_pkg::ST_IDLE;
      d.drvOe = 4'h0;
      d.held = 1'b0;
      d.csPrev = 1'b0;
      d.modeLoad = 1'b0;
      if (!BATTERY_BACKED) begin
        d.width = sram_pkg::BUS_ONE;
        d.mode = sram_pkg::MODE_RESET;
      end
    end

    d.oeLive = (holdAllowed && !ioIn[3]) ? 4'h0 : d.drvOe;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= RESET_ST;
    end else begin
      q <= d;
    end
  end

  assign ioOut = q.ioOut;
  assign ioOe = q.oeLive;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_DESELECT_IDLE: assert property (csN |=> q.state == sram_pkg::ST_IDLE)
    else $error("deselect did not return to idle");
  AST_IDLE_FLOATS: assert property (q.state == sram_pkg::ST_IDLE |-> q.oeLive == 4'h0)
    else $error("outputs driven while idle");
  AST_ADDR_LOW_BITS: assert property (addrDone |=> q.ptr == $past(srNext[ADDR_W-1:0]))
    else $error("address not taken from low bits");
  AST_SPI_NO_DUMMY: assert property (addrDone && !q.isWrite && q.width == sram_pkg::BUS_ONE
    |=> q.state == sram_pkg::ST_RD_DATA)
    else $error("single-bit read did not start at once");
  AST_WIDE_DUMMY: assert property ($rose(q.state == sram_pkg::ST_RD_DATA)
    && q.width != sram_pkg::BUS_ONE |-> $past(q.state) == sram_pkg::ST_DUMMY
    && $past(q.dummyCnt) + 3'h1 == ((q.width == sram_pkg::BUS_TWO) ?
    sram_pkg::DUMMY_TWO_BIT : sram_pkg::DUMMY_FOUR_BIT))
    else $error("wrong dummy count before read data");
  AST_READ_ADVANCE: assert property (fall && !csN && powerGood
    && q.state == sram_pkg::ST_RD_DATA && q.outCnt == 3'h0
    |=> q.ptr == ADDR_W'($past(q.ptr) + 1'b1) && q.rdReq)
    else $error("read pointer did not advance");
  AST_PAGE_WRAP: assert property (byteDone && !csN && powerGood
    && q.mode[7:6] == sram_pkg::WMODE_PAGE |=> q.ptr[ADDR_W-1:5] == $past(q.ptr[ADDR_W-1:5])
    && q.ptr[4:0] == 5'($past(q.ptr[4:0]) + 1'b1))
    else $error("page write left its page");
  AST_BURST_STEP: assert property (byteDone && !csN && powerGood
    && q.mode[7:6] == sram_pkg::WMODE_BURST |=> q.ptr == ADDR_W'($past(q.ptr) + 1'b1))
    else $error("burst pointer did not advance");
  AST_WORD_STOP: assert property (byteDone && !csN && powerGood
    && q.mode[7:6] == sram_pkg::WMODE_WORD |=> q.state == sram_pkg::ST_IGNORE ##1
    (q.bufCnt != 2'h0 || q.wrPend || memWe))
    else $error("word write not stopped or not stored");
  AST_MODE_COMMIT: assert property (csN && q.modeLoad && powerGood
    |=> q.mode == $past(q.modePend) && !q.modeLoad)
    else $error("mode register write not committed");
  AST_NO_FOUR_BIT: assert property (BATTERY_BACKED |-> q.width != sram_pkg::BUS_FOUR)
    else $error("battery variant entered four-bit mode");
  AST_RETAIN: assert property (!powerGood && BATTERY_BACKED && !(csN && q.modeLoad)
    |=> q.mode == $past(q.mode) && q.width == $past(q.width))
    else $error("settings lost on battery switch-over");
  AST_PAUSE_FLOAT: assert property (holdAllowed && !ioIn[3] |=> q.oeLive == 4'h0)
    else $error("output driven during pause");

  COV_READ: cover property (q.state == sram_pkg::ST_RD_DATA && fall && q.outCnt == 3'h0);
  COV_WRITE: cover property (byteDone ##[1:200] byteDone);
  COV_MODE_READ: cover property (q.state == sram_pkg::ST_MODE_RD && fall);
  COV_PAUSE: cover property ($rose(q.held) ##[1:100] $fell(q.held));

endmodule

// ### sram_array.sv
// Single-port byte array with registered read data.
`timescale 1ns/1ps
module sram_array #(
  parameter int ADDR_W = sram_pkg::ADDR_W,
  parameter int DATA_W = sram_pkg::DATA_W
) (
  input wire logic clk,
  input wire logic en,
  input wire logic we,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata
);

  logic [DATA_W-1:0] mem [2**ADDR_W];

  // Contents are kept across resets and supply loss on purpose.
  always_ff @(posedge clk) begin
    if (en && we) begin
      mem[addr] <= wdata;
    end
    if (en && !we) begin
      rdata <= mem[addr];
    end
  end

endmodule

// ### sram_host_model.sv
// Host controller model that drives the serial link and samples the device answers.
`timescale 1ns/1ps
module sram_host_model (
  output logic csN,
  output logic sck,
  output logic [3:0] ioIn,
  input wire logic clk,
  input wire logic [3:0] ioOut,
  input wire logic [3:0] ioOe,
  input wire logic [3:0] altOut
);
  logic [3:0] drv;
  logic pauseN;
  int width;

  // The wire follows the device where it drives, elsewhere this host.
  assign ioIn = (ioOe & ioOut) | (~ioOe & drv);

  initial begin
    csN = 1'b1;
    sck = 1'b0;
    drv = 4'hf;
    pauseN = 1'b1;
    width = 1;
  end

  function automatic logic [3:0] dataMask();
    return width == 1 ? 4'h1 : (width == 2 ? 4'h3 : 4'hf);
  endfunction

  task automatic waitClk(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic select();
    waitClk(1);
    csN = 1'b0;
    waitClk(2);
  endtask

  // Released lines 2:0 show the inverse of their last value; line 3 goes high.
  task automatic deselect();
    waitClk(2);
    csN = 1'b1;
    drv = {1'b1, ~drv[2:0]};
    waitClk(3);
  endtask

  task automatic setPause(input logic v);
    pauseN = v;
    drv[3] = v;
  endtask

  // Data changes while the serial clock is low and is taken on its rise.
  task automatic beat(input logic [3:0] d, input bit own, output logic [3:0] o,
                      output logic a);
    logic [3:0] m;
    m = own ? dataMask() : 4'h0;
    drv = (d & m) | (~drv & ~m);
    if (width < 4) begin
      drv[3] = pauseN;
    end
    waitClk(4);
    o = ioIn;
    a = altOut[1];
    sck = 1'b1;
    waitClk(4);
    sck = 1'b0;
  endtask

  task automatic xfer(input int nBits, input logic [31:0] val, input bit own,
                      output logic [31:0] got, output logic [31:0] got2);
    logic [3:0] o;
    logic a;
    int s;
    got = '0;
    got2 = '0;
    s = nBits;
    while (s > 0) begin
      s -= width;
      beat(4'(val >> s), own, o, a);
      if (width == 1) begin
        got = {got[30:0], o[1]};
      end else begin
        got = (got << width) | 32'(o & dataMask());
      end
      got2 = {got2[30:0], a};
    end
  endtask
endmodule

// ### sram_pkg.sv
// Shared constants, types and helper functions of the serial SRAM command interface.
package sram_pkg;

  // ==========================================================================
  // Array and field sizes
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int PAGE_BITS = 5;
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] BYTE_BITS = 6'h08;
  localparam logic [2:0] DUMMY_TWO_BIT = 3'h4;
  localparam logic [2:0] DUMMY_FOUR_BIT = 3'h2;

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_ENTER_FOUR_BIT = 8'h38;
  localparam logic [7:0] OP_ENTER_TWO_BIT = 8'h3b;
  localparam logic [7:0] OP_RETURN_SINGLE_BIT = 8'hff;
  localparam logic [7:0] OP_READ_MODE_REG = 8'h05;
  localparam logic [7:0] OP_WRITE_MODE_REG = 8'h01;

  // ==========================================================================
  // Mode register layout
  localparam int HOLD_DIS_BIT = 0;
  localparam int WMODE_HI = 7;
  localparam int WMODE_LO = 6;
  localparam logic [1:0] WMODE_WORD = 2'h0;
  localparam logic [1:0] WMODE_PAGE = 2'h2;
  localparam logic [1:0] WMODE_BURST = 2'h1;
  localparam logic [7:0] MODE_RESET = 8'h40;

  typedef enum logic [2:0] {
    BUS_ONE = 3'b001,
    BUS_TWO = 3'b010,
    BUS_FOUR = 3'b100
  } width_e;

  typedef enum logic [8:0] {
    ST_IDLE = 9'b000000001,
    ST_CMD = 9'b000000010,
    ST_ADDR = 9'b000000100,
    ST_DUMMY = 9'b000001000,
    ST_RD_DATA = 9'b000010000,
    ST_WR_DATA = 9'b000100000,
    ST_MODE_RD = 9'b001000000,
    ST_MODE_WR = 9'b010000000,
    ST_IGNORE = 9'b100000000
  } state_e;

  // ==========================================================================
  // Width helpers
  function automatic logic [5:0] bitsPer(input width_e w);
    case (w)
      BUS_TWO: bitsPer = 6'h02;
      BUS_FOUR: bitsPer = 6'h04;
      default: bitsPer = 6'h01;
    endcase
  endfunction

  function automatic logic [31:0] shiftIn(input logic [31:0] sr, input logic [3:0] io,
                                          input width_e w);
    case (w)
      BUS_TWO: shiftIn = {sr[29:0], io[1:0]};
      BUS_FOUR: shiftIn = {sr[27:0], io[3:0]};
      default: shiftIn = {sr[30:0], io[0]};
    endcase
  endfunction

  // Single-bit output leaves on line 1; wider modes use the low lines.
  function automatic logic [3:0] drive(input logic [7:0] word, input width_e w);
    case (w)
      BUS_TWO: drive = {2'h0, word[7:6]};
      BUS_FOUR: drive = word[7:4];
      default: drive = {2'h0, word[7], 1'b0};
    endcase
  endfunction

  function automatic logic [3:0] oeMask(input width_e w);
    case (w)
      BUS_TWO: oeMask = 4'h3;
      BUS_FOUR: oeMask = 4'hf;
      default: oeMask = 4'h2;
    endcase
  endfunction

  function automatic logic [2:0] lastBeat(input width_e w);
    case (w)
      BUS_TWO: lastBeat = 3'h3;
      BUS_FOUR: lastBeat = 3'h1;
      default: lastBeat = 3'h7;
    endcase
  endfunction

endpackage

// ### test_serial_sram_command_interface.sv
// Self-checking testbench of the serial SRAM command interface.
`timescale 1ns/1ps
module test_serial_sram_command_interface;
  logic clk;
  logic rst_n;
  logic powerGood;
  wire csN;
  wire sck;
  wire [3:0] ioIn;
  logic [3:0] ioOut;
  logic [3:0] ioOe;
  logic [3:0] bbOut;
  logic [3:0] bbOe;
  int bad_count;
  int compares;
  int cycles = 0;
  logic [31:0] r;
  logic [31:0] r2;

  serial_sram_command_interface serial_sram_command_interface_inst (
    .clk(clk), .rst_n(rst_n), .powerGood(powerGood), .csN(csN), .sck(sck),
    .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));
  serial_sram_command_interface #(.BATTERY_BACKED(1'b1)) serial_sram_command_interface_bb_inst (
    .clk(clk), .rst_n(rst_n), .powerGood(powerGood), .csN(csN), .sck(sck),
    .ioIn(ioIn), .ioOut(bbOut), .ioOe(bbOe));
  sram_host_model sram_host_model_inst (
    .clk(clk), .csN(csN), .sck(sck), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
    .altOut(bbOut));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================================================
  // Reporting
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      conclude();
    end
  end

  // ==========================================================================
  // Transactions
  task automatic send(input int n, input logic [31:0] v);
    sram_host_model_inst.xfer(n, v, 1'b1, r, r2);
  endtask

  task automatic recv(input int n);
    sram_host_model_inst.xfer(n, 32'h0, 1'b0, r, r2);
  endtask

  task automatic op(input logic [7:0] c, input int w);
    sram_host_model_inst.select();
    send(8, 32'(c));
    sram_host_model_inst.deselect();
    sram_host_model_inst.width = w;
  endtask

  task automatic wrMem(input logic [23:0] a, input logic [31:0] v, input int n);
    sram_host_model_inst.select();
    send(8, 32'(sram_pkg::OP_WRITE));
    send(24, 32'(a));
    send(8 * n, v);
    sram_host_model_inst.deselect();
  endtask

  task automatic rdMem(input logic [23:0] a, input int n, input logic [31:0] exp);
    sram_host_model_inst.select();
    send(8, 32'(sram_pkg::OP_READ));
    send(24, 32'(a));
    // Four two-bit or two four-bit dummy beats are eight bit times either way.
    if (sram_host_model_inst.width > 1) begin
      recv(8);
    end
    recv(8 * n);
    sram_host_model_inst.deselect();
    check("read data", exp, r);
  endtask

  task automatic wrMode(input logic [7:0] v);
    sram_host_model_inst.select();
    send(8, 32'(sram_pkg::OP_WRITE_MODE_REG));
    send(8, 32'(v));
    sram_host_model_inst.deselect();
  endtask

  task automatic rdMode(input logic [15:0] exp);
    sram_host_model_inst.select();
    send(8, 32'(sram_pkg::OP_READ_MODE_REG));
    recv(16);
    sram_host_model_inst.deselect();
    check("mode register", 32'(exp), r);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic powerUpState();
    check("idle enables", 32'h0, 32'(ioOe));
    check("battery idle enables", 32'h0, 32'(bbOe));
    rdMode(16'h4040);
    check("battery mode register", 32'h4040, r2);
  endtask

  task automatic burstWrap();
    wrMem(24'hff_ffff, 32'ha55a, 2);
    rdMem(24'h01_ffff, 2, 32'ha55a);
    rdMem(24'h80_0000, 1, 32'h5a);
  endtask

  task automatic pageWrap();
    wrMem(24'h00_003f, 32'h9977, 2);
    wrMode(8'h80);
    rdMode(16'h8080);
    wrMem(24'h00_003f, 32'h1122, 2);
    rdMem(24'h00_003f, 2, 32'h1177);
    rdMem(24'h00_0020, 1, 32'h22);
  endtask

  task automatic wordMode();
    wrMode(8'h00);
    wrMem(24'h00_003f, 32'h3344, 2);
    rdMem(24'h00_003f, 2, 32'h3377);
    wrMode(8'h40);
  endtask

  task automatic pausedRead();
    logic [3:0] hi;
    sram_host_model_inst.select();
    send(8, 32'(sram_pkg::OP_READ));
    send(24, 32'h3f);
    recv(4);
    hi = r[3:0];
    sram_host_model_inst.setPause(1'b0);
    sram_host_model_inst.waitClk(4);
    check("enables in pause", 32'h0, 32'(ioOe));
    sram_host_model_inst.setPause(1'b1);
    recv(4);
    sram_host_model_inst.deselect();
    check("paused read", 32'h33, {24'h0, hi, r[3:0]});
  endtask

  task automatic wideModes();
    op(sram_pkg::OP_ENTER_TWO_BIT, 2);
    rdMem(24'h00_003f, 2, 32'h3377);
    wrMem(24'h00_0050, 32'hc3, 1);
    rdMem(24'h00_0050, 1, 32'hc3);
    rdMode(16'h4040);
    op(sram_pkg::OP_RETURN_SINGLE_BIT, 1);
    rdMem(24'h00_0050, 1, 32'hc3);
    op(sram_pkg::OP_ENTER_FOUR_BIT, 4);
    rdMem(24'h00_003f, 2, 32'h3377);
    wrMem(24'h00_0060, 32'h5aa5, 2);
    rdMem(24'h00_0060, 2, 32'h5aa5);
    op(sram_pkg::OP_RETURN_SINGLE_BIT, 1);
  endtask

  task automatic batteryBackup();
    wrMode(8'h81);
    rdMode(16'h8181);
    check("battery mode write", 32'h8181, r2);
    powerGood = 1'b0;
    sram_host_model_inst.waitClk(4);
    powerGood = 1'b1;
    sram_host_model_inst.waitClk(4);
    rdMode(16'h4040);
    check("battery mode kept", 32'h8181, r2);
    op(sram_pkg::OP_ENTER_FOUR_BIT, 1);
    // Supply loss drops the standard part back to one-bit; the battery part never left it.
    powerGood = 1'b0;
    sram_host_model_inst.waitClk(4);
    powerGood = 1'b1;
    sram_host_model_inst.waitClk(4);
    rdMode(16'h4040);
    check("battery stays one bit", 32'h8181, r2);
  endtask

  initial begin
    rst_n = 1'b0;
    powerGood = 1'b1;
    bad_count = 0;
    compares = 0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    powerUpState();
    burstWrap();
    pageWrap();
    wordMode();
    pausedRead();
    wideModes();
    batteryBackup();
    conclude();
  end
endmodule
